// *** rtl/lmk_pkg.sv ***
/* Constants and types for the LED matrix controller with key scan.
   Assumes a 100 MHz system clock and a slow serial host on pins. */
// How it works
// (RL1) First byte after frame select falls is a command, later bytes data.
// (RL2) Frame select rising mid-byte resets the receiver, drops partial byte.
// (RL3) Shift clock edges are ignored while frame select is high.
// (RL4) Input bit taken on rising shift clock, least significant bit first.
// (RL5) Open-drain key output changes on each falling shift clock edge.
// (RL6) Key return inputs are captured at the end of each key scan step, not always.
// (RL7) Mode command picks 4/14, 5/13, 6/12 or 7/11; reset is 7/11.
// (RL8) A mode command repeating the current mode does nothing.
// (RL9) After a mode change the display stays off until turned on.
// (RL10) Data setting command is 01xx_xxxx; low four bits reset to zero.
// (RL11) Data setting bit 3 picks normal (0) or test (1) operation.
// (RL12) Data setting bit 2: 0 increments address per byte, 1 fixes it.
// (RL13) Data setting bits 1:0: 00 writes display data, 10 reads keys.
// (RL14) Five key bytes; KEY_RETURN_INPUTS of odd line in bits 0,1, even in 3,4.
// (RL15) Address command loads 4-bit address; 0EH and up drop data.
// (RL16) Two RAM bytes per digit: segments 1-8 then 9-14.
// (RL17) Control command bit 3 turns display on; key scan keeps running.
// (RL18) Control bits 2:0 pick pulse width 1,2,4,10..14 sixteenths.
// (RL19) Reset gives 1/16 width, display off, scanning stopped.
// (RL20) A key scan cycle spans two frames into a 10x2 key store.
// (RL21) Host waits at least 1 us before clocking out key data.
// (RL22) Host sends mode, data, address, up to 14 bytes, then control.
// (RL23) Grids lit one at a time, each only for its pulse width.
package lmk_pkg;
   localparam int unsigned RAM_BYTES  = 14;
   localparam int unsigned KEY_LINES  = 10;
   localparam int unsigned KEY_BITS   = 40;
   localparam int unsigned KEY_STEPS  = 5;
   localparam logic [3:0]  GRID_BASE  = 4'h4;
   localparam logic [1:0]  MODE_RST   = 2'h3;
   localparam logic [3:0]  DSET_RST   = 4'h0;
   localparam logic [3:0]  ADDR_RST   = 4'h0;
   localparam logic [3:0]  ADDR_MAX   = 4'hD;
   localparam logic [2:0]  DIM_RST    = 3'h0;
   localparam logic [1:0]  CMD_MODE   = 2'h0;
   localparam logic [1:0]  CMD_DATA   = 2'h1;
   localparam logic [1:0]  CMD_CTRL   = 2'h2;
   localparam logic [1:0]  CMD_ADDR   = 2'h3;
   localparam logic [1:0]  RW_WRITE   = 2'h0;
   localparam logic [1:0]  RW_READ    = 2'h2;
   localparam int unsigned DSET_TEST  = 3;
   localparam int unsigned DSET_FIX   = 2;
   localparam int unsigned CTRL_ON    = 3;
   localparam logic [4:0]  DIM_TAB [8] = '{5'h01, 5'h02, 5'h04, 5'h0A,
                                          5'h0B, 5'h0C, 5'h0D, 5'h0E};
   localparam logic [15:0] SLOT_DIV_RST = 16'h0040;
   localparam logic [3:0]  REG_CFG    = 4'h0;
   localparam logic [3:0]  REG_STAT   = 4'h4;
   localparam logic [3:0]  REG_KEY0   = 4'h8;
   localparam logic [3:0]  REG_KEY1   = 4'hC;
   typedef struct packed {
      logic       rd;
      logic       scan;
      logic [2:0] dim;
      logic       on;
      logic [3:0] addr;
      logic [3:0] dset;
      logic [1:0] mode;
   } lmk_stat_s;
endpackage : lmk_pkg

// *** rtl/lmk_link_if.sv ***
/* Link between serial front end and command core.
   Assumes both ends run on the same system clock. */
`timescale 1ns/100ps
`default_nettype none
interface lmk_link_if;
   logic                        rx_valid;
   logic                        rx_cmd;
   logic [7:0]                  rx_byte;
   logic                        idle;
   logic                        rd_en;
   logic [lmk_pkg::KEY_BITS-1:0] key_bits;
   modport ser  (output rx_valid, rx_cmd, rx_byte, idle,
                 input  rd_en, key_bits);
   modport core (input  rx_valid, rx_cmd, rx_byte, idle,
                 output rd_en, key_bits);
endinterface : lmk_link_if
`default_nettype wire

// *** rtl/lmk_serial.sv ***
/* Serial front end: synchronises pins, shifts bytes in, keys out.
   Assumes host shift clock far slower than the system clock. */
`timescale 1ns/100ps
`default_nettype none
module lmk_serial (
   input  wire logic  clk_i,
   input  wire logic  reset_n_i,
   input  wire logic  sclk_i,
   input  wire logic  sdi_i,
   input  wire logic  frame_select_n_i,
   output logic       data_oe_o,
   lmk_link_if.ser    lnk
);
   logic [2:0] ck_q;
   logic [1:0] di_q;
   logic [1:0] fs_q;
   logic [7:0] sr_q;
   logic [2:0] bit_q;
   logic       first_q;
   logic       valid_q;
   logic       cmd_q;
   logic [5:0] idx_q;
   logic       rise;
   logic       fall;

   // ****************
   // Synchronisers
   // ****************
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ck_q <= 3'h7;
         di_q <= 2'h0;
         fs_q <= 2'h3;
      end else begin
         ck_q <= {ck_q[1:0], sclk_i};
         di_q <= {di_q[0], sdi_i};
         fs_q <= {fs_q[0], frame_select_n_i};
      end
   end

   assign rise = ck_q[1] & ~ck_q[2];
   assign fall = ~ck_q[1] & ck_q[2];

   // ****************
   // Receiver
   // ****************
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sr_q    <= 8'h00;
         bit_q   <= 3'h0;
         first_q <= 1'b1;
         valid_q <= 1'b0;
         cmd_q   <= 1'b0;
      end else begin
         valid_q <= 1'b0;
         if (fs_q[1]) begin
            bit_q   <= 3'h0; // RL2
            first_q <= 1'b1; // RL1
         end else if (rise) begin // RL3
            sr_q  <= {di_q[1], sr_q[7:1]}; // RL4
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7) begin
               valid_q <= 1'b1;
               cmd_q   <= first_q; // RL1
               first_q <= 1'b0;
            end
         end
      end
   end

   // ****************
   // Key output
   // ****************
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         idx_q     <= 6'h00;
         data_oe_o <= 1'b0;
      end else if (fs_q[1] || !lnk.rd_en) begin
         idx_q     <= 6'h00;
         data_oe_o <= 1'b0;
      end else if (fall) begin
         if (idx_q < 6'(lmk_pkg::KEY_BITS)) begin
            data_oe_o <= ~lnk.key_bits[idx_q]; // RL5
            idx_q     <= idx_q + 6'h01;
         end else begin
            data_oe_o <= 1'b0;
         end
      end
   end

   assign lnk.rx_valid = valid_q;
   assign lnk.rx_cmd   = cmd_q;
   assign lnk.rx_byte  = sr_q;
   assign lnk.idle     = fs_q[1];
endmodule : lmk_serial
`default_nettype wire

// *** rtl/lmk_top.sv ***
/* LED matrix controller with key scan: command core, display RAM,
   grid multiplexer, key scanner and Avalon-MM register slave.
   Assumes host pins asynchronous to clk_i; Avalon master on clk_i. */
`timescale 1ns/100ps
`default_nettype none
module lmk_top (
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        sclk_i,
   input  wire logic        sdi_i,
   input  wire logic        frame_select_n_i,
   output logic             data_out_o,
   output logic             data_oe_o,
   input  wire logic [1:0]  key_return_inputs_i,
   output logic [9:0]       segment_key_source_lines_o,
   output logic             segment_line_eleven_o,
   output logic [2:0]       shared_segment_grid_lines_o,
   output logic [3:0]       grid_lines_o,
   input  wire logic [3:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [3:0]  avs_byteenable_i,
   input  wire logic [31:0] avs_writedata_i,
   output logic [31:0]      avs_readdata_o,
   output logic             avs_waitrequest_o
);
   lmk_link_if lnk ();

   logic [1:0]  mode_q;
   logic [3:0]  dset_q;
   logic [3:0]  addr_q;
   logic        on_q;
   logic [2:0]  dim_q;
   logic        scan_q;
   logic        rd_q;
   logic [7:0]  ram_q [lmk_pkg::RAM_BYTES];
   logic [1:0]  key_q [lmk_pkg::KEY_LINES];
   logic [1:0]  kr1_q;
   logic [1:0]  kr2_q;
   logic [15:0] div_q;
   logic [15:0] unit_q;
   logic [3:0]  sx_q;
   logic [3:0]  step_q;
   logic        par_q;
   logic [3:0]  n_grid;
   logic [3:0]  last_step;
   logic [3:0]  line;
   logic [15:0] div_m1;
   logic        tick;
   logic [13:0] seg_d;
   logic [6:0]  grid_d;
   logic [9:0]  src_d;
   logic [3:0]  ev_idx;
   logic [3:0]  od_idx;
   logic [7:0]  cmd;
   lmk_pkg::lmk_stat_s stat;

   // ****************
   // Serial front end
   // ****************
   lmk_serial u_serial (
      .clk_i            (clk_i),
      .reset_n_i        (reset_n_i),
      .sclk_i           (sclk_i),
      .sdi_i            (sdi_i),
      .frame_select_n_i (frame_select_n_i),
      .data_oe_o        (data_oe_o),
      .lnk              (lnk.ser)
   );

   assign cmd       = lnk.rx_byte;
   assign lnk.rd_en = rd_q;

   // Open-drain line only ever pulls low
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         data_out_o <= 1'b0;
      end else begin
         data_out_o <= 1'b0;
      end
   end

   // ****************
   // Command decode
   // ****************
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mode_q <= lmk_pkg::MODE_RST; // RL7
         dset_q <= lmk_pkg::DSET_RST; // RL10
         addr_q <= lmk_pkg::ADDR_RST; // RL15
         on_q   <= 1'b0; // RL19
         dim_q  <= lmk_pkg::DIM_RST; // RL19
         scan_q <= 1'b0; // RL19
         rd_q   <= 1'b0;
      end else begin
         if (lnk.rx_valid && lnk.rx_cmd) begin // RL1
            unique case (cmd[7:6])
               lmk_pkg::CMD_MODE: begin
                  if (cmd[1:0] != mode_q) begin // RL8
                     mode_q <= cmd[1:0]; // RL7
                     on_q   <= 1'b0; // RL9
                  end
               end
               lmk_pkg::CMD_DATA: begin
                  dset_q <= cmd[3:0]; // RL10
                  rd_q   <= (cmd[1:0] == lmk_pkg::RW_READ); // RL13
               end
               lmk_pkg::CMD_CTRL: begin
                  on_q   <= cmd[lmk_pkg::CTRL_ON]; // RL17
                  dim_q  <= cmd[2:0]; // RL18
                  scan_q <= 1'b1; // RL17
               end
               lmk_pkg::CMD_ADDR: begin
                  addr_q <= cmd[3:0]; // RL15
               end
            endcase
         end else if (lnk.rx_valid) begin
            if (dset_q[1:0] == lmk_pkg::RW_WRITE &&
                addr_q <= lmk_pkg::ADDR_MAX &&
                !dset_q[lmk_pkg::DSET_FIX]) begin
               addr_q <= addr_q + 4'h1; // RL12
            end
         end
         if (lnk.idle) begin
            rd_q <= 1'b0;
         end
      end
   end

   // ****************
   // Display RAM
   // ****************
   always_ff @(posedge clk_i) begin
      if (lnk.rx_valid && !lnk.rx_cmd &&
          dset_q[1:0] == lmk_pkg::RW_WRITE &&
          addr_q <= lmk_pkg::ADDR_MAX) begin // RL15
         ram_q[addr_q] <= cmd; // RL16
      end
   end

   // ****************
   // Scan timing
   // ****************
   assign n_grid    = lmk_pkg::GRID_BASE + {2'b00, mode_q}; // RL7
   assign last_step = n_grid + 4'(lmk_pkg::KEY_STEPS - 1);
   assign div_m1    = (div_q == 16'h0000) ? 16'h0000 : div_q - 16'h0001;
   assign tick      = (unit_q >= div_m1);
   assign line      = (step_q - n_grid) + (par_q ? 4'h5 : 4'h0);

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         unit_q <= 16'h0000;
         sx_q   <= 4'h0;
         step_q <= 4'h0;
         par_q  <= 1'b0;
      end else begin
         unit_q <= tick ? 16'h0000 : unit_q + 16'h0001;
         if (tick) begin
            sx_q <= sx_q + 4'h1;
            if (sx_q == 4'hF) begin
               if (step_q >= last_step) begin
                  step_q <= 4'h0;
                  par_q  <= ~par_q; // RL20
               end else begin
                  step_q <= step_q + 4'h1;
               end
            end
         end
      end
   end

   // ****************
   // Key store
   // ****************
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         kr1_q <= 2'h0;
         kr2_q <= 2'h0;
      end else begin
         kr1_q <= key_return_inputs_i;
         kr2_q <= kr1_q;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         for (int i = 0; i < lmk_pkg::KEY_LINES; i++) begin
            key_q[i] <= 2'h0;
         end
      end else if (scan_q && tick && sx_q == 4'hF &&
                   step_q >= n_grid) begin
         key_q[line] <= kr2_q; // RL6
      end
   end

   for (genvar g = 0; g < lmk_pkg::KEY_STEPS; g++) begin : g_key
      assign lnk.key_bits[8*g +: 8] =
         {3'b000, key_q[2*g+1], 1'b0, key_q[2*g]}; // RL14
   end

   // ****************
   // Segment and grid drive
   // ****************
   assign ev_idx = {step_q[2:0], 1'b0};
   assign od_idx = {step_q[2:0], 1'b1};

   always_comb begin
      seg_d  = 14'h0000;
      grid_d = 7'h00;
      src_d  = 10'h000;
      if (step_q < n_grid) begin
         if (on_q && {1'b0, sx_q} < lmk_pkg::DIM_TAB[dim_q]) begin // RL18
            if (dset_q[lmk_pkg::DSET_TEST]) begin
               seg_d = 14'h3FFF; // RL11
            end else begin
               seg_d = {ram_q[od_idx][5:0], ram_q[ev_idx]}; // RL16
            end
            grid_d[step_q[2:0]] = 1'b1; // RL23
         end
      end else if (scan_q) begin
         src_d[line] = 1'b1; // RL20
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         segment_key_source_lines_o  <= 10'h000;
         segment_line_eleven_o       <= 1'b0;
         shared_segment_grid_lines_o <= 3'h0;
         grid_lines_o                <= 4'h0;
      end else begin
         segment_key_source_lines_o <= seg_d[9:0] | src_d;
         segment_line_eleven_o      <= seg_d[10];
         grid_lines_o               <= grid_d[3:0];
         for (int i = 0; i < 3; i++) begin
            if (2'(i) < 2'h3 - mode_q) begin // RL7
               shared_segment_grid_lines_o[i] <= seg_d[11+i];
            end else begin
               shared_segment_grid_lines_o[i] <= grid_d[6-i];
            end
         end
      end
   end

   // ****************
   // Avalon-MM slave
   // ****************
   assign stat = '{rd: rd_q, scan: scan_q, dim: dim_q, on: on_q,
                   addr: addr_q, dset: dset_q, mode: mode_q};

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o    <= 32'h0000_0000;
      end else begin
         avs_waitrequest_o <= 1'b1;
         if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
            avs_waitrequest_o <= 1'b0;
            avs_readdata_o    <= 32'h0000_0000;
            if (avs_read_i) begin
               unique case (avs_address_i)
                  lmk_pkg::REG_CFG:
                     avs_readdata_o <= {16'h0000, div_q};
                  lmk_pkg::REG_STAT:
                     avs_readdata_o <= {16'h0000, stat};
                  lmk_pkg::REG_KEY0:
                     avs_readdata_o <= lnk.key_bits[31:0];
                  lmk_pkg::REG_KEY1:
                     avs_readdata_o <= {24'h00_0000,
                                        lnk.key_bits[39:32]};
                  default:
                     avs_readdata_o <= 32'h0000_0000;
               endcase
            end
         end
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         div_q <= lmk_pkg::SLOT_DIV_RST;
      end else if (avs_write_i && !avs_waitrequest_o &&
                   avs_address_i == lmk_pkg::REG_CFG) begin
         if (avs_byteenable_i[0]) begin
            div_q[7:0] <= avs_writedata_i[7:0];
         end
         if (avs_byteenable_i[1]) begin
            div_q[15:8] <= avs_writedata_i[15:8];
         end
      end
   end
endmodule : lmk_top
`default_nettype wire

// *** sim/lmk_monitor.sv ***
/* Port checker for lmk_top, bound into every instance.
   Assumes the bench sets the slot divider to 1 before display on. */
`timescale 1ns/100ps
`default_nettype none
module lmk_monitor (
   input wire logic        clk_i,
   input wire logic        reset_n_i,
   input wire logic        sclk_i,
   input wire logic        frame_select_n_i,
   input wire logic        data_out_o,
   input wire logic        data_oe_o,
   input wire logic [9:0]  segment_key_source_lines_o,
   input wire logic [3:0]  grid_lines_o,
   input wire logic [3:0]  avs_address_i,
   input wire logic        avs_read_i,
   input wire logic        avs_write_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic        avs_waitrequest_o
);
   logic       seen_q;
   logic [4:0] lit_q;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   // ****************
   // Helper state
   // ****************
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         seen_q <= 1'b0;
      end else if (!frame_select_n_i) begin
         seen_q <= 1'b1;
      end
   end
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         lit_q <= 5'h00;
      end else if (grid_lines_o == 4'h0) begin
         lit_q <= 5'h00;
      end else if (lit_q != 5'h1F) begin
         lit_q <= lit_q + 5'h01;
      end
   end
   // ****************
   // Assertions
   // ****************
   chk_dout_low: assert property (
      data_out_o == 1'b0) else $error("data value not low");
   chk_oe_on_fall: assert property (
      $rose(data_oe_o) |-> !sclk_i && !frame_select_n_i)
      else $error("key bit driven off a falling shift clock");
   chk_oe_idle: assert property (
      frame_select_n_i [*8] |-> !data_oe_o)
      else $error("data line driven outside a frame");
   chk_power_blank: assert property (
      !seen_q |-> grid_lines_o == 4'h0
                  && segment_key_source_lines_o == 10'h000)
      else $error("outputs active before any command");
   chk_grid_single: assert property (
      $onehot0(grid_lines_o)) else $error("several grids lit");
   chk_pulse_width: assert property (
      lit_q <= 5'h0E) else $error("grid lit longer than 14 sixteenths");
   chk_key_spare: assert property (
      avs_read_i && !avs_waitrequest_o && avs_address_i[3]
      |-> (avs_readdata_o & (avs_address_i[2] ? 32'hFFFF_FFE4
                                               : 32'hE4E4_E4E4)) == 0)
      else $error("spare key bits not zero");
   chk_wait_pulse: assert property (
      !avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low for more than one cycle");
   chk_wait_answer: assert property (
      $rose(avs_read_i || avs_write_i) |-> ##[1:2] !avs_waitrequest_o)
      else $error("bus request not answered");
endmodule : lmk_monitor
bind lmk_top lmk_monitor u_mon (
   .clk_i(clk_i), .reset_n_i(reset_n_i), .sclk_i(sclk_i),
   .frame_select_n_i(frame_select_n_i), .data_out_o(data_out_o),
   .data_oe_o(data_oe_o),
   .segment_key_source_lines_o(segment_key_source_lines_o),
   .grid_lines_o(grid_lines_o), .avs_address_i(avs_address_i),
   .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
   .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o));
`default_nettype wire

// *** sim/lmk_host_model.sv ***
/* Host controller model on the four-wire serial pins.
   Assumes a pull-up on the key data line; the bench calls its tasks. */
`timescale 1ns/100ps
`default_nettype none
module lmk_host_model (
   input  wire logic clk_i,
   output logic      sclk_o,
   output logic      sdi_o,
   output logic      frame_select_n_o,
   input  wire logic data_oe_i
);
   localparam real HALF = 62.5;
   initial begin
      sclk_o           = 1'b1;
      sdi_o            = 1'b0;
      frame_select_n_o = 1'b1;
   end
   task automatic align();
      @(negedge clk_i);
      #1;
   endtask : align
   task automatic open_frame();
      align();
      frame_select_n_o = 1'b0;
      #500;
   endtask : open_frame
   task automatic close_frame();
      #1000;
      frame_select_n_o = 1'b1;
      sdi_o            = ~sdi_o;
      #1000;
   endtask : close_frame
   task automatic put(input logic [7:0] b, input int n);
      align();
      for (int i = 0; i < n; i++) begin
         sclk_o = 1'b0;
         sdi_o  = b[i];
         #HALF;
         sclk_o = 1'b1;
         #HALF;
      end
   endtask : put
   task automatic get(output logic [7:0] b);
      align();
      for (int i = 0; i < 8; i++) begin
         sclk_o = 1'b0;
         #HALF;
         sclk_o = 1'b1;
         b[i]   = ~data_oe_i;
         #HALF;
      end
   endtask : get
   task automatic cmd(input logic [7:0] c);
      open_frame();
      put(c, 8);
      close_frame();
   endtask : cmd
endmodule : lmk_host_model
`default_nettype wire

// *** sim/tb.sv ***
/* Self-checking bench for lmk_top with host model and Avalon tasks.
   Assumes the monitor file binds its checker into lmk_top. */
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic        clk_i     = 1'b0;
   logic        reset_n_i = 1'b0;
   logic        sclk, sdi, fsn, dout, oe, seg11, wreq;
   logic [1:0]  keys  = 2'b00;
   logic [9:0]  seg;
   logic [2:0]  shared;
   logic [3:0]  grid;
   logic [3:0]  addr  = 4'h0;
   logic        rd    = 1'b0;
   logic        wr    = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] rdata, got;
   logic [7:0]  kb, kr;
   logic [13:0] e14;
   logic [3:0]  be    = 4'hF;
   int          err_count = 0;
   int          n_checks  = 0;
   always #5 clk_i = ~clk_i;
   lmk_host_model host (.clk_i(clk_i), .sclk_o(sclk), .sdi_o(sdi),
      .frame_select_n_o(fsn), .data_oe_i(oe));
   lmk_top uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .sclk_i(sclk),
      .sdi_i(sdi), .frame_select_n_i(fsn), .data_out_o(dout),
      .data_oe_o(oe), .key_return_inputs_i(keys),
      .segment_key_source_lines_o(seg), .segment_line_eleven_o(seg11),
      .shared_segment_grid_lines_o(shared), .grid_lines_o(grid),
      .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_byteenable_i(be), .avs_writedata_i(wdata),
      .avs_readdata_o(rdata), .avs_waitrequest_o(wreq));
   // ****************
   // Tasks
   // ****************
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : test_done
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
      int k;
      @(posedge clk_i);
      rd    <= !w;
      wr    <= w;
      addr  <= a;
      wdata <= d;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (wreq !== 1'b0 && k < 50);
      if (k >= 50) begin
         err_count++;
         test_done();
      end
      got = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus
   task automatic fld(input int lsb, input logic [31:0] m,
                      input logic [31:0] e);
      bus(1'b0, 4'h4, 32'h0000_0000);
      check((got >> lsb) & m, e);
   endtask : fld
   task automatic digit(input logic [3:0] g, input logic [2:0] sh,
                        input logic [13:0] e);
      int k;
      k = 0;
      while ({shared, grid} !== {sh, g} && k < 5000) begin
         @(posedge clk_i);
         k++;
      end
      if (k >= 5000) begin
         err_count++;
         test_done();
      end
      check({18'h0, shared, seg11, seg}, {18'h0, sh, e[10:0]});
   endtask : digit
   function automatic logic [7:0] pat(input int i);
      return 8'hA5 ^ 8'(i * 29);
   endfunction : pat
   function automatic logic [13:0] dig(input int d);
      logic [7:0] hi;
      hi = pat(2 * d + 1);
      return {hi[5:0], pat(2 * d)};
   endfunction : dig
   // ****************
   // Sequence
   // ****************
   initial begin
      #1_000_000;
      err_count++;
      test_done();
   end
   initial begin
      repeat (5) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      fld(0, 32'hFFFF, 32'h0003);
      bus(1'b0, 4'h0, 32'h0); check(got, 32'h0000_0040);
      bus(1'b0, 4'h3, 32'h0); check(got, 32'h0000_0000);
      be <= 4'h1;
      bus(1'b1, 4'h0, 32'hA5A5_3C01);
      be <= 4'hF;
      bus(1'b0, 4'h0, 32'h0); check(got, 32'h0000_0001);
      bus(1'b1, 4'h4, 32'hFFFF_FFFF); fld(0, 32'h3, 32'h3);
      for (int d = 0; d < 16; d++) begin
         host.cmd(8'h70 | 8'(d));
         fld(2, 32'hF, 32'(d));
      end
      for (int k = 0; k < 8; k++) begin
         host.cmd(8'h88 | 8'(k));
         fld(10, 32'h1F, 32'(2 * k + 17));
      end
      host.cmd(8'h80); fld(10, 32'h1F, 32'h10);
      host.cmd(8'h88); host.cmd(8'h3F); fld(10, 32'h1, 32'h1);
      for (int m = 0; m < 4; m++) begin
         host.cmd(8'h88);
         host.cmd(8'(m));
         fld(0, 32'h403, 32'(m));
      end
      host.cmd(8'hCD); fld(6, 32'hF, 32'hD);
      host.open_frame(); host.put(8'hC3, 4); host.close_frame();
      fld(6, 32'hF, 32'hD);
      host.put(8'hC1, 8); fld(6, 32'hF, 32'hD);
      host.cmd(8'h03); host.cmd(8'h40);
      host.open_frame(); host.put(8'hC0, 8);
      for (int i = 0; i < 14; i++) host.put(pat(i), 8);
      host.close_frame(); host.cmd(8'h8F);
      digit(4'h1, 3'h0, dig(0));
      digit(4'h2, 3'h0, dig(1));
      digit(4'h0, 3'h1, dig(6));
      host.cmd(8'h44); host.open_frame(); host.put(8'hC4, 8);
      host.put(8'h11, 8); host.put(8'h22, 8); host.close_frame();
      e14 = dig(2);
      e14[7:0] = 8'h22;
      digit(4'h4, 3'h0, e14);
      host.cmd(8'h48); digit(4'h1, 3'h0, 14'h3FFF);
      host.cmd(8'h40); host.cmd(8'h00); host.cmd(8'h8F);
      e14 = dig(0);
      digit(4'h1, e14[13:11], e14);
      for (int k = 1; k < 3; k++) begin
         @(posedge clk_i);
         keys <= 2'(k);
         repeat (1000) @(posedge clk_i);
         kb = 8'(k) | 8'(k << 3);
         bus(1'b0, 4'h8, 32'h0); check(got, {4{kb}});
         bus(1'b0, 4'hC, 32'h0); check(got, {24'h0, kb});
         host.open_frame(); host.put(8'h42, 8);
         #1000;
         for (int i = 0; i < 5; i++) begin
            host.get(kr);
            check({24'h0, kr}, {24'h0, kb});
         end
         host.close_frame();
      end
      test_done();
   end
endmodule : tb
`default_nettype wire
